// ==== design/via_arbiter.sv ====
// Interrupt pending, arbitration, acknowledge and vector-select logic.
// Notes on behaviour
// - Each non-trap source has enable and pending.
// - Source event sets its pending flag.
// - Maskable trigger needs pending, enable, global enable, boundary.
// - Trap service holds off maskable interrupts.
// - Highest rank wins, others stay pending.
// - Reset clears pending, enables, global enable.
// - Already-pending source fires once enabled.
// - Acknowledge only at next executed instruction.
// - Ack clears global enable, pushes address, jumps 00FF.
// - Acknowledge sequence lasts seven cycles.
// - Return sets global enable and pops address.
// - Pending interrupt serviced right after return.
// - Vector-select jumps through winner's table entry.
// - Table is 32 bytes atop page.
// - Vector-select at page end uses next page.
// - Vector is 15 bits, high byte first.
// - Slot offsets E0 lowest up to FE trap.
// - Trap ranks highest, default entry lowest.
// - Eleven sources with fixed rank and slot.
// - Even offset replaces low PC byte; at page end the page also steps.
// - No active source selects default E0 entry.
// - Trap pending cleared by clear instruction, reset.
`timescale 1ns/10ps
module via_arbiter
    import via_pkg::*;
#(
    parameter int ACK_CYCLES = VIA_ACK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic [15:0] src_event,
    input wire via_seq_req_t seq_req,
    input wire logic [7:0] prog_rdata,
    output via_seq_rsp_t seq_rsp
);
    if (ACK_CYCLES < 3 || ACK_CYCLES > 15)
    begin : g_bad_ack
        $error("via_arbiter: ACK_CYCLES must lie between 3 and 15");
    end

    localparam int ACK_SPAN = ACK_CYCLES - 1;
    localparam logic [3:0] ACK_LAST = 4'(ACK_CYCLES - 2);

    logic [15:0] pnd_reg;
    logic [15:0] pnd_next;
    logic [15:0] en_reg;
    logic [15:0] en_next;
    logic global_irq_enable_reg;
    logic global_irq_enable_next;
    logic nmi_svc_reg;
    logic nmi_svc_next;
    via_state_t state_reg;
    via_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [6:0] vec_hi_reg;
    logic [6:0] vec_hi_next;
    via_seq_rsp_t rsp_reg;
    via_seq_rsp_t rsp_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Register port decode.
    wire wr_status = bus_wr && (bus_addr == VIA_REG_STATUS);
    wire wr_en_lo = bus_wr && (bus_addr == VIA_REG_EN_LO);
    wire wr_en_hi = bus_wr && (bus_addr == VIA_REG_EN_HI);
    wire wr_pnd_lo = bus_wr && (bus_addr == VIA_REG_PND_LO);
    wire wr_pnd_hi = bus_wr && (bus_addr == VIA_REG_PND_HI);

    wire [15:0] active = pnd_reg & en_reg & VIA_MASKABLE;
    wire trap_pnd = pnd_reg[VIA_TRAP_SLOT];
    wire [15:0] ev_m = src_event & VIA_MASKABLE;

    wire maskable_req = (|active) && global_irq_enable_reg && !nmi_svc_reg;
    wire trap_req = trap_pnd && !nmi_svc_reg;
    wire idle = (state_reg == VIA_IDLE) && !rsp_reg.busy;
    wire take = seq_req.instr_start && !seq_req.skip && idle && (maskable_req || trap_req);
    wire vis_go = seq_req.vis_exec && idle && !take;
    wire return_from_irq_go = seq_req.return_from_irq_exec && idle && !take;

    wire [15:0] vis_active = active | {trap_pnd, 15'h0000};
    wire [3:0] win_slot;
    wire win_any;

    via_prio_enc #(
        .N(VIA_SLOTS),
        .SW(VIA_SLOT_W)
    ) u_enc (
        .active(vis_active),
        .slot(win_slot),
        .any(win_any)
    );

    wire [7:0] vis_offset = VIA_TABLE_BASE + {3'b000, win_slot, 1'b0};
    wire page_end = (seq_req.instr_addr[7:0] == VIA_PAGE_LAST);
    wire [6:0] vis_page = page_end ? 7'(seq_req.instr_addr[14:8] + 7'h01) : seq_req.instr_addr[14:8];
    wire [14:0] table_addr = {vis_page, vis_offset};

    wire [15:0] pnd_written = {wr_pnd_hi ? bus_wdata : pnd_reg[15:8], wr_pnd_lo ? bus_wdata : pnd_reg[7:0]};
    wire [15:0] pnd_mask_next = (pnd_written | ev_m) & VIA_MASKABLE;
    wire trap_next = seq_req.trap_exec || (trap_pnd && !seq_req.clear_nonmaskable_pending_exec);
    assign pnd_next = pnd_mask_next | {trap_next, 15'h0000};

    wire [15:0] en_written = {wr_en_hi ? bus_wdata : en_reg[15:8], wr_en_lo ? bus_wdata : en_reg[7:0]};
    assign en_next = en_written & VIA_MASKABLE;

    assign global_irq_enable_next = take ? 1'b0 :
                                    return_from_irq_go ? 1'b1 :
                                    wr_status ? bus_wdata[VIA_ST_GIE] :
                                    global_irq_enable_reg;

    assign nmi_svc_next = (take && trap_req) ? 1'b1 :
                          return_from_irq_go ? 1'b0 :
                          nmi_svc_reg;

    // Read mux; data stands only in the cycle after the read strobe.
    wire [7:0] status_byte = {4'h0, rsp_reg.busy, trap_pnd, nmi_svc_reg, global_irq_enable_reg};
    wire [7:0] rd_sel = (bus_addr == VIA_REG_STATUS) ? status_byte :
                        (bus_addr == VIA_REG_EN_LO) ? en_reg[7:0] :
                        (bus_addr == VIA_REG_EN_HI) ? en_reg[15:8] :
                        (bus_addr == VIA_REG_PND_LO) ? pnd_reg[7:0] :
                        (bus_addr == VIA_REG_PND_HI) ? pnd_reg[15:8] :
                        VIA_RESET_BYTE;
    assign rdata_next = bus_rd ? rd_sel : VIA_RESET_BYTE;

    // Sequencing of acknowledge and vector-select.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        vec_hi_next = vec_hi_reg;
        rsp_next = rsp_reg;
        rsp_next.busy = 1'b0;
        rsp_next.push_req = 1'b0;
        rsp_next.pop_req = 1'b0;
        rsp_next.pc_load = 1'b0;
        rsp_next.mem_rd = 1'b0;
        case (state_reg)
            VIA_IDLE:
            begin
                if (take)
                begin
                    state_next = VIA_ACK;
                    cnt_next = 4'h0;
                    rsp_next.busy = 1'b1;
                    rsp_next.push_req = 1'b1;
                    rsp_next.push_addr = seq_req.instr_addr;
                end
                else if (vis_go)
                begin
                    state_next = VIA_VIS_HI;
                    rsp_next.busy = 1'b1;
                    rsp_next.mem_rd = 1'b1;
                    rsp_next.mem_addr = table_addr;
                end
                else if (return_from_irq_go)
                begin
                    rsp_next.pop_req = 1'b1;
                end
            end
            VIA_ACK:
            begin
                rsp_next.busy = 1'b1;
                cnt_next = 4'(cnt_reg + 4'h1);
                if (cnt_reg == ACK_LAST)
                begin
                    rsp_next.pc_load = 1'b1;
                    rsp_next.pc_value = VIA_ENTRY_ADDR;
                    state_next = VIA_IDLE;
                end
            end
            VIA_VIS_HI:
            begin
                rsp_next.busy = 1'b1;
                rsp_next.mem_rd = 1'b1;
                rsp_next.mem_addr = 15'(rsp_reg.mem_addr + 15'h0001);
                state_next = VIA_VIS_LO;
            end
            VIA_VIS_LO:
            begin
                rsp_next.busy = 1'b1;
                vec_hi_next = prog_rdata[6:0];
                state_next = VIA_VIS_JMP;
            end
            VIA_VIS_JMP:
            begin
                rsp_next.busy = 1'b1;
                rsp_next.pc_load = 1'b1;
                rsp_next.pc_value = {vec_hi_reg, prog_rdata};
                state_next = VIA_IDLE;
            end
            default:
            begin
                state_next = VIA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pnd_reg <= VIA_RESET_WORD;
            en_reg <= VIA_RESET_WORD;
            global_irq_enable_reg <= 1'b0;
            nmi_svc_reg <= 1'b0;
            state_reg <= VIA_IDLE;
            cnt_reg <= 4'h0;
            vec_hi_reg <= 7'h00;
            rsp_reg <= '0;
            rdata_reg <= VIA_RESET_BYTE;
        end
        else
        begin
            pnd_reg <= pnd_next;
            en_reg <= en_next;
            global_irq_enable_reg <= global_irq_enable_next;
            nmi_svc_reg <= nmi_svc_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            vec_hi_reg <= vec_hi_next;
            rsp_reg <= rsp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign seq_rsp = rsp_reg;

    // Checks on the guarded behaviour.
    sequence s_push;
        rsp_reg.push_req && rsp_reg.busy && !global_irq_enable_reg;
    endsequence

    sequence s_entry;
        rsp_reg.pc_load && rsp_reg.busy && (rsp_reg.pc_value == VIA_ENTRY_ADDR);
    endsequence

    property p_pend_set;
        @(posedge clk) disable iff (reset)
        (|ev_m) |=> ((pnd_reg & $past(ev_m)) == $past(ev_m));
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("event did not set pending");

    property p_reset_clear;
        @(posedge clk)
        reset |=> (pnd_reg == VIA_RESET_WORD) && (en_reg == VIA_RESET_WORD) && !global_irq_enable_reg;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left flags set");

    property p_take_cause;
        @(posedge clk) disable iff (reset)
        take |-> (trap_req || (global_irq_enable_reg && !nmi_svc_reg && (|active)));
    endproperty
    a_take_cause: assert property (p_take_cause) else $error("acknowledge without cause");

    property p_hold_off;
        @(posedge clk) disable iff (reset)
        (nmi_svc_reg && !trap_pnd && state_reg == VIA_IDLE) |=> !rsp_reg.push_req;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("maskable taken during trap service");

    property p_skip;
        @(posedge clk) disable iff (reset)
        (seq_req.skip || !seq_req.instr_start) |=> !rsp_reg.push_req;
    endproperty
    a_skip: assert property (p_skip) else $error("acknowledge off an executed boundary");

    property p_ack_seq;
        @(posedge clk) disable iff (reset)
        take |=> s_push ##ACK_SPAN s_entry ##1 !rsp_reg.busy;
    endproperty
    a_ack_seq: assert property (p_ack_seq) else $error("acknowledge sequence length wrong");

    property p_ack_push;
        @(posedge clk) disable iff (reset)
        take |=> rsp_reg.push_addr == $past(seq_req.instr_addr);
    endproperty
    a_ack_push: assert property (p_ack_push) else $error("wrong return address pushed");

    property p_return_from_irq;
        @(posedge clk) disable iff (reset)
        return_from_irq_go |=> global_irq_enable_reg && rsp_reg.pop_req && !nmi_svc_reg;
    endproperty
    a_return_from_irq: assert property (p_return_from_irq) else $error("return did not restore enable");

    property p_vis_addr;
        @(posedge clk) disable iff (reset)
        vis_go |=> rsp_reg.mem_rd && (rsp_reg.mem_addr == $past(table_addr)) ##1 rsp_reg.mem_rd;
    endproperty
    a_vis_addr: assert property (p_vis_addr) else $error("vector table address wrong");

    property p_vis_default;
        @(posedge clk) disable iff (reset)
        (vis_go && (vis_active == VIA_RESET_WORD)) |=> rsp_reg.mem_addr[7:0] == VIA_TABLE_BASE;
    endproperty
    a_vis_default: assert property (p_vis_default) else $error("default entry not used");

    property p_trap_top;
        @(posedge clk) disable iff (reset)
        (vis_go && trap_pnd) |=> rsp_reg.mem_addr[7:0] == VIA_TRAP_OFFSET;
    endproperty
    a_trap_top: assert property (p_trap_top) else $error("trap did not win arbitration");

    property p_vis_jump;
        @(posedge clk) disable iff (reset)
        (state_reg == VIA_VIS_JMP) |=> rsp_reg.pc_load && (rsp_reg.pc_value == {$past(vec_hi_reg), $past(prog_rdata)});
    endproperty
    a_vis_jump: assert property (p_vis_jump) else $error("vector assembled wrongly");

    property p_clear_nonmaskable_pending;
        @(posedge clk) disable iff (reset)
        (seq_req.clear_nonmaskable_pending_exec && !seq_req.trap_exec) |=> !trap_pnd;
    endproperty
    a_clear_nonmaskable_pending: assert property (p_clear_nonmaskable_pending) else $error("trap pending not cleared");
endmodule // via_arbiter

// ==== design/via_prio_enc.sv ====
// Fixed-rank priority encoder: the highest active slot index wins.
`timescale 1ns/10ps
module via_prio_enc
    import via_pkg::*;
#(
    parameter int N = VIA_SLOTS,
    parameter int SW = VIA_SLOT_W
)
(
    input wire logic [N-1:0] active,
    output logic [SW-1:0] slot,
    output logic any
);
    if (N < 2 || N > (1 << SW))
    begin : g_bad_size
        $error("via_prio_enc: N does not fit the slot width");
    end

    // Later iterations overwrite earlier ones, so the top index ranks first.
    always_comb
    begin
        slot = '0;
        any = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            if (active[i])
            begin
                slot = SW'(i);
                any = 1'b1;
            end
        end
    end
endmodule // via_prio_enc

// ==== shared/via_pkg.sv ====
// Constants and carrier types shared by the vectored interrupt arbiter.
package via_pkg;
    // Vector slots: slot 0 is the default entry, slot 15 the software trap.
    localparam int VIA_SLOTS = 16;
    localparam int VIA_SLOT_W = 4;
    localparam int VIA_AW = 15;
    localparam int VIA_TRAP_SLOT = 15;
    // Slots that carry a maskable source; reserved slots stay unimplemented.
    localparam logic [15:0] VIA_MASKABLE = 16'h3fe2;
    localparam logic [7:0] VIA_TABLE_BASE = 8'he0;
    localparam logic [7:0] VIA_TRAP_OFFSET = 8'hfe;
    localparam logic [7:0] VIA_PAGE_LAST = 8'hff;
    localparam logic [14:0] VIA_ENTRY_ADDR = 15'h00ff;
    localparam int VIA_ACK_CYCLES = 7;

    // Register offsets on the plain register port.
    localparam logic [3:0] VIA_REG_STATUS = 4'h0;
    localparam logic [3:0] VIA_REG_EN_LO = 4'h1;
    localparam logic [3:0] VIA_REG_EN_HI = 4'h2;
    localparam logic [3:0] VIA_REG_PND_LO = 4'h3;
    localparam logic [3:0] VIA_REG_PND_HI = 4'h4;

    // Status register fields.
    localparam int VIA_ST_GIE = 0;
    localparam int VIA_ST_NMI_SVC = 1;
    localparam int VIA_ST_TRAP_PND = 2;
    localparam int VIA_ST_BUSY = 3;

    localparam logic [7:0] VIA_RESET_BYTE = 8'h00;
    localparam logic [15:0] VIA_RESET_WORD = 16'h0000;

    typedef enum {VIA_IDLE, VIA_ACK, VIA_VIS_HI, VIA_VIS_LO, VIA_VIS_JMP} via_state_t;

    // Requests from the instruction sequencer.
    typedef struct packed {
        logic instr_start;
        logic skip;
        logic [14:0] instr_addr;
        logic vis_exec;
        logic return_from_irq_exec;
        logic clear_nonmaskable_pending_exec;
        logic trap_exec;
    } via_seq_req_t;

    // Answers to the instruction sequencer and program memory.
    typedef struct packed {
        logic busy;
        logic push_req;
        logic [14:0] push_addr;
        logic pop_req;
        logic pc_load;
        logic [14:0] pc_value;
        logic mem_rd;
        logic [14:0] mem_addr;
    } via_seq_rsp_t;
endpackage

// ==== verif/vectored_interrupt_arbiter_tb.sv ====
// Self-checking testbench for the vectored interrupt arbiter.
`timescale 1ns/10ps
module vectored_interrupt_arbiter_tb
    import via_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic [15:0] src_event = 16'h0000;
    via_seq_req_t seq_req = '0;
    logic [7:0] prog_rdata;
    via_seq_rsp_t seq_rsp;
    int err_total = 0;
    int checks = 0;
    logic [15:0] pnd;

    always #2.5 clk = ~clk;

    via_arbiter via_arbiter_inst (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .src_event(src_event), .seq_req(seq_req),
        .prog_rdata(prog_rdata), .seq_rsp(seq_rsp));
    via_prog_mem via_prog_mem_inst (.clk(clk), .seq_rsp(seq_rsp), .prog_rdata(prog_rdata));

    task final_report;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk_reg(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task chk_addr(input logic [14:0] g, input logic [14:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task chk_flag(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [7:0] mem_byte(input logic [14:0] a);
        return a[7:0] ^ {1'b0, a[14:8]};
    endfunction

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk_reg(bus_rdata, e);
        // Read data stands for one cycle only, then the port shows zero.
        @(posedge clk);
        #1;
        chk_reg(bus_rdata, 8'h00);
    endtask

    // Kind 0 start, 1 vector select, 2 return, 3 clear trap pending, 4 trap.
    task seq_op(input int kind, input logic [14:0] a, input logic sk);
        @(posedge clk);
        seq_req.instr_addr <= a;
        seq_req.skip <= sk;
        seq_req.instr_start <= (kind == 0);
        seq_req.vis_exec <= (kind == 1);
        seq_req.return_from_irq_exec <= (kind == 2);
        seq_req.clear_nonmaskable_pending_exec <= (kind == 3);
        seq_req.trap_exec <= (kind == 4);
        @(posedge clk);
        seq_req <= '0;
        #1;
    endtask

    task no_ack;
        chk_flag(seq_rsp.busy, 1'b0);
        chk_flag(seq_rsp.push_req, 1'b0);
    endtask

    task start_ack(input logic [14:0] ra);
        int n;
        seq_op(0, ra, 1'b0);
        chk_flag(seq_rsp.push_req, 1'b1);
        chk_addr(seq_rsp.push_addr, ra);
        n = 1;
        while (seq_rsp.pc_load !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_reg(n[7:0], 8'(VIA_ACK_CYCLES));
        chk_addr(seq_rsp.pc_value, 15'h00ff);
        @(posedge clk);
        #1;
        chk_flag(seq_rsp.busy, 1'b0);
    endtask

    task vis_check(input logic [14:0] a, input logic [3:0] s);
        logic [6:0] page;
        logic [14:0] va;
        logic [7:0] hi;
        logic [7:0] lo;
        int n;
        page = (a[7:0] == 8'hff) ? a[14:8] + 7'h01 : a[14:8];
        va = {page, 8'he0 + {3'b000, s, 1'b0}};
        hi = mem_byte(va);
        lo = mem_byte(va + 15'h0001);
        seq_op(1, a, 1'b0);
        chk_flag(seq_rsp.mem_rd, 1'b1);
        chk_addr(seq_rsp.mem_addr, va);
        @(posedge clk);
        #1;
        chk_flag(seq_rsp.mem_rd, 1'b1);
        chk_addr(seq_rsp.mem_addr, va + 15'h0001);
        n = 2;
        while (seq_rsp.pc_load !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_reg(n[7:0], 8'h04);
        chk_addr(seq_rsp.pc_value, {hi[6:0], lo});
        @(posedge clk);
        #1;
        chk_flag(seq_rsp.busy, 1'b0);
    endtask

    initial
    begin
        #(20000 * 5);
        err_total++;
        final_report;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(i[3:0], 8'h00);
        rd_chk(4'hf, 8'h00);
        @(posedge clk);
        src_event <= 16'hffff;
        @(posedge clk);
        src_event <= 16'h0000;
        rd_chk(VIA_REG_PND_LO, 8'he2);
        rd_chk(VIA_REG_PND_HI, 8'h3f);
        rd_chk(VIA_REG_STATUS, 8'h00);
        seq_op(0, 15'h0100, 1'b0);
        no_ack;
        wr(VIA_REG_EN_LO, 8'hff);
        wr(VIA_REG_EN_HI, 8'hff);
        rd_chk(VIA_REG_EN_HI, 8'h3f);
        seq_op(0, 15'h0101, 1'b0);
        no_ack;
        wr(VIA_REG_STATUS, 8'h01);
        start_ack(15'h0102);
        rd_chk(VIA_REG_STATUS, 8'h00);
        vis_check(15'h00ff, 4'd13);
        pnd = 16'h3fe2;
        for (int s = 13; s >= 1; s--)
        begin
            if (VIA_MASKABLE[s])
            begin
                vis_check(15'h0312, s[3:0]);
                pnd[s] = 1'b0;
                wr(VIA_REG_PND_LO, pnd[7:0]);
                wr(VIA_REG_PND_HI, pnd[15:8]);
            end
        end
        vis_check(15'h0312, 4'd0);
        seq_op(2, 15'h0000, 1'b0);
        chk_flag(seq_rsp.pop_req, 1'b1);
        rd_chk(VIA_REG_STATUS, 8'h01);
        @(posedge clk);
        src_event <= 16'h0040;
        @(posedge clk);
        src_event <= 16'h0000;
        seq_op(0, 15'h0200, 1'b1);
        no_ack;
        start_ack(15'h0201);
        seq_op(4, 15'h0000, 1'b0);
        rd_chk(VIA_REG_STATUS, 8'h04);
        seq_op(2, 15'h0000, 1'b0);
        start_ack(15'h0202);
        rd_chk(VIA_REG_STATUS, 8'h06);
        vis_check(15'h0400, 4'd15);
        // Trap service holds off maskable requests even after software sets the global enable.
        wr(VIA_REG_STATUS, 8'h01);
        seq_op(3, 15'h0000, 1'b0);
        rd_chk(VIA_REG_STATUS, 8'h03);
        seq_op(0, 15'h0203, 1'b0);
        no_ack;
        seq_op(2, 15'h0000, 1'b0);
        start_ack(15'h0204);
        vis_check(15'h0500, 4'd6);
        // A reset in mid-run must clear enables, pending flags and the global enable.
        wr(VIA_REG_STATUS, 8'h01);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(VIA_REG_EN_LO, 8'h00);
        rd_chk(VIA_REG_PND_LO, 8'h00);
        rd_chk(VIA_REG_STATUS, 8'h00);
        chk_addr(seq_rsp.pc_value, 15'h0000);
        chk_addr(seq_rsp.push_addr, 15'h0000);
        final_report;
    end
endmodule // vectored_interrupt_arbiter_tb

// ==== verif/via_prog_mem.sv ====
// Program memory model that answers vector fetches from the arbiter.
`timescale 1ns/10ps
module via_prog_mem
    import via_pkg::*;
(
    input wire logic clk,
    input wire via_seq_rsp_t seq_rsp,
    output logic [7:0] prog_rdata
);
    initial prog_rdata = 8'h00;

    // Outside a fetch the data toggles every cycle, so stale bytes never look valid.
    always @(posedge clk)
    begin
        if (seq_rsp.mem_rd)
            prog_rdata <= seq_rsp.mem_addr[7:0] ^ {1'b0, seq_rsp.mem_addr[14:8]};
        else
            prog_rdata <= ~prog_rdata;
    end
endmodule // via_prog_mem
